// >>> tdd_engine.sv
// Transfer descriptor fetch, decode, execute and write-back engine
// Operation
// - Issue at most the packet multiplier count of packets per execution.
// - Each packet carries at most max_packet_bytes from word 0 bits 28:18.
// - total_byte_count in word 0 bits 17:3 bounds bytes moved.
// - Clear valid flag after full completion or fatal error.
// - Longer periods use power-of-two frame field ranges, one mask bit.
// - Endpoint number joins word 0 bit 31 with word 1 bits 2:0 as its upper bits.
// - Word 1 holds hub address, hub port, split, kind, token, address, endpoint.
// - Word 2 holds reload field and sixteen-bit buffer start address.
// - Bulk split descriptors run as start-split and complete-split.
// - Buffer address is in 8-byte internal units above the processor base.
// - Frame field match then microframe mask decides issue per microframe.
// - Polling period is two to the (b-1) microframes, b one to nine.
// - Split flag zero means high-speed, one means split transaction.
`timescale 1ns/1ps
module tdd_engine
	import tdd_pkg::*;
#(
	parameter int SLOT_BITS = 5
)(
	input  wire logic                   clk_sys,
	input  wire logic                   rst_b,
	input  wire logic                   sofTick,
	input  wire logic                   scanEnable,
	input  wire logic [SLOT_BITS-1:0]   slotIndex,
	input  wire logic [10:0]            frameNumber,
	input  wire logic [2:0]             microframeIndex,
	output logic                        memRdReq,
	output logic                        memWrEn,
	output logic [SLOT_BITS+2:0]        memAddr,
	output logic [31:0]                 memWrData,
	input  wire logic                   memRdValid,
	input  wire logic [31:0]            memRdData,
	output logic                        txnStart,
	output logic [1:0]                  txnToken,
	output logic [1:0]                  txnKind,
	output logic [6:0]                  txnFunctionAddr,
	output logic [3:0]                  txnEndpoint,
	output logic [10:0]                 txnMaxBytes,
	output logic [10:0]                 txnLen,
	output logic [15:0]                 txnBufAddr,
	output logic                        txnToggle,
	output logic                        txnSplit,
	output logic [6:0]                  txnHubAddr,
	output logic [6:0]                  txnHubPort,
	input  wire logic                   txnDone,
	input  wire logic [10:0]            txnBytes,
	input  wire logic                   txnFatal,
	input  wire logic                   txnToggleNext,
	output logic                        descBusy,
	output logic                        descRetire,
	output logic                        descFault
);
	generate
		if (SLOT_BITS < 1 || SLOT_BITS > 16)
			$error("SLOT_BITS out of range");
	endgenerate

	tdd_state_t      state_reg;
	logic [31:0]     descWords_reg [DESC_WORDS];
	logic [2:0]      wordIdx_reg;
	logic [1:0]      pktLeft_reg;
	logic [1:0]      issued_reg;
	logic [14:0]     doneCnt_reg;
	logic            toggle_reg;
	logic            finished_reg;
	logic            fatal_reg;

	// Decoded fields
	wire logic [31:0] w0         = descWords_reg[W_CTRL];
	wire logic [31:0] w1         = descWords_reg[W_ROUTE];
	wire logic [31:0] w2         = descWords_reg[W_BUF];
	wire logic [31:0] w3         = descWords_reg[W_STAT];
	wire logic        validFlag  = w0[VALID_BIT];
	wire logic [1:0]  multField  = w0[MULT_HI:MULT_LO];
	wire logic [1:0]  multEff    = (multField == MULT_UNDEF) ? MULT_SINGLE : multField;
	wire logic [10:0] maxPkt     = w0[MAXPKT_HI:MAXPKT_LO];
	wire logic [14:0] totalBytes = w0[TOTAL_HI:TOTAL_LO];
	wire logic [3:0]  epNumber   = {w1[EP_UP_HI:EP_UP_LO], w0[EP_LOW_BIT]};
	wire logic [1:0]  epKind     = w1[KIND_HI:KIND_LO];
	wire logic [15:0] bufStart   = w2[BUF_HI:BUF_LO];
	wire logic [14:0] remaining  = totalBytes - doneCnt_reg;
	wire logic [10:0] lenNow     = (remaining > {4'h0, maxPkt}) ? maxPkt : remaining[10:0];
	wire logic [14:0] doneNext   = doneCnt_reg + {4'h0, txnBytes};
	wire logic        shortPkt   = txnBytes < txnLen;
	wire logic        lastWord   = wordIdx_reg == W_LAST;
	wire logic        due;

	tdd_poll_check u_poll (
		.clk_sys         (clk_sys),
		.rst_b           (rst_b),
		.isPeriodic      (epKind == KIND_INTERRUPT),
		.frameField      (w2[FRAME_HI:FRAME_LO]),
		.slotMask        (descWords_reg[W_SLOT][MASK_HI:0]),
		.frameLow        (frameNumber[4:0]),
		.microframeIndex (microframeIndex),
		.due             (due)
	);

	// Descriptor word capture
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < DESC_WORDS; i++)
				descWords_reg[i] <= 32'h00000000;
		end
		else if (state_reg == ST_FETCH && memRdValid)
			descWords_reg[wordIdx_reg] <= memRdData;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg       <= ST_IDLE;
			wordIdx_reg     <= 3'h0;
			pktLeft_reg     <= 2'h0;
			issued_reg      <= 2'h0;
			doneCnt_reg     <= 15'h0000;
			toggle_reg      <= 1'b0;
			finished_reg    <= 1'b0;
			fatal_reg       <= 1'b0;
			memRdReq        <= 1'b0;
			memWrEn         <= 1'b0;
			memAddr         <= '0;
			memWrData       <= 32'h00000000;
			txnStart        <= 1'b0;
			txnToken        <= 2'h0;
			txnKind         <= 2'h0;
			txnFunctionAddr <= 7'h00;
			txnEndpoint     <= 4'h0;
			txnMaxBytes     <= 11'h000;
			txnLen          <= 11'h000;
			txnBufAddr      <= 16'h0000;
			txnToggle       <= 1'b0;
			txnSplit        <= 1'b0;
			txnHubAddr      <= 7'h00;
			txnHubPort      <= 7'h00;
			descBusy        <= 1'b0;
			descRetire      <= 1'b0;
			descFault       <= 1'b0;
		end
		else
		begin
			memRdReq   <= 1'b0;
			memWrEn    <= 1'b0;
			txnStart   <= 1'b0;
			descRetire <= 1'b0;
			descFault  <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					descBusy <= 1'b0;
					if (sofTick && scanEnable)
					begin
						state_reg   <= ST_FETCH;
						wordIdx_reg <= 3'h0;
						memRdReq    <= 1'b1;
						memAddr     <= {slotIndex, W_CTRL};
						descBusy    <= 1'b1;
					end
				end
				ST_FETCH:
				begin
					if (memRdValid)
					begin
						if (lastWord)
							state_reg <= ST_CHECK;
						else
						begin
							wordIdx_reg <= wordIdx_reg + 3'h1;
							memRdReq    <= 1'b1;
							memAddr     <= {slotIndex, wordIdx_reg + 3'h1};
						end
					end
				end
				ST_CHECK:
				begin
					doneCnt_reg  <= w3[DONE_HI:0];
					toggle_reg   <= w3[TOGGLE_BIT];
					pktLeft_reg  <= multEff;
					issued_reg   <= 2'h0;
					finished_reg <= 1'b0;
					fatal_reg    <= 1'b0;
					if (!validFlag || !due)
						state_reg <= ST_IDLE;
					else if (w3[DONE_HI:0] >= totalBytes)
					begin
						finished_reg <= 1'b1;
						state_reg    <= ST_WB3;
					end
					else
						state_reg <= ST_ISSUE;
				end
				ST_ISSUE:
				begin
					txnStart        <= 1'b1;
					txnToken        <= w1[TOKEN_HI:TOKEN_LO];
					txnKind         <= epKind;
					txnFunctionAddr <= w1[FADDR_HI:FADDR_LO];
					txnEndpoint     <= epNumber;
					txnMaxBytes     <= maxPkt;
					txnLen          <= lenNow;
					txnBufAddr      <= bufStart + {4'h0, doneCnt_reg[14:RAM_UNIT_LOG2]};
					txnToggle       <= toggle_reg;
					txnSplit        <= w1[SPLIT_BIT];
					txnHubAddr      <= w1[HUB_HI:HUB_LO];
					txnHubPort      <= w1[PORT_HI:PORT_LO];
					issued_reg      <= issued_reg + 2'h1;
					state_reg       <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (txnDone)
					begin
						doneCnt_reg <= doneNext;
						toggle_reg  <= txnToggleNext;
						pktLeft_reg <= pktLeft_reg - 2'h1;
						if (txnFatal)
						begin
							fatal_reg <= 1'b1;
							state_reg <= ST_WB3;
						end
						else if (shortPkt || doneNext >= totalBytes)
						begin
							finished_reg <= 1'b1;
							state_reg    <= ST_WB3;
						end
						else if (pktLeft_reg == 2'h1)
							state_reg <= ST_WB3;
						else
							state_reg <= ST_ISSUE;
					end
				end
				ST_WB3:
				begin
					memWrEn   <= 1'b1;
					memAddr   <= {slotIndex, W_STAT};
					memWrData <= {!(finished_reg || fatal_reg), fatal_reg,
						w3[29:26], toggle_reg, w3[24:15], doneCnt_reg};
					state_reg <= (finished_reg || fatal_reg) ? ST_WB0 : ST_IDLE;
				end
				ST_WB0:
				begin
					memWrEn    <= 1'b1;
					memAddr    <= {slotIndex, W_CTRL};
					memWrData  <= {w0[31:1], 1'b0};
					descRetire <= finished_reg;
					descFault  <= fatal_reg;
					state_reg  <= ST_IDLE;
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	a_skip_invalid: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_reg == ST_CHECK && !validFlag) |=> (state_reg == ST_IDLE) ##1 !txnStart)
		else $error("invalid descriptor was executed");
	a_len_cap: assert property (@(posedge clk_sys) disable iff (!rst_b)
		txnStart |-> (txnLen <= txnMaxBytes) && (txnMaxBytes == maxPkt))
		else $error("packet longer than max_packet_bytes");
	a_total_cap: assert property (@(posedge clk_sys) disable iff (!rst_b)
		txnStart |-> (16'(doneCnt_reg) + 16'(txnLen)) <= 16'(totalBytes))
		else $error("transfer exceeds total_byte_count");
	a_pkt_count: assert property (@(posedge clk_sys) disable iff (!rst_b)
		txnStart |-> (issued_reg != 2'h0) && (issued_reg <= multEff))
		else $error("more packets than the multiplier allows");
	a_valid_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(memWrEn && memAddr[2:0] == W_CTRL) |-> !memWrData[VALID_BIT]
			&& (memWrData[31:1] == w0[31:1]) && $past(state_reg) == ST_WB0)
		else $error("word 0 write-back altered fields or kept valid");
	a_retire_path: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_reg == ST_WAIT && txnDone && txnFatal) |=> ##1 memWrEn ##1 (memWrEn && descFault))
		else $error("fatal error did not clear valid");
	a_endpoint_join: assert property (@(posedge clk_sys) disable iff (!rst_b)
		txnStart |-> txnEndpoint == {w1[EP_UP_HI:EP_UP_LO], w0[EP_LOW_BIT]})
		else $error("endpoint number mis-assembled");
	a_split_select: assert property (@(posedge clk_sys) disable iff (!rst_b)
		txnStart |-> (txnSplit == w1[SPLIT_BIT]) && (txnHubPort == w1[PORT_HI:PORT_LO]))
		else $error("split routing fields wrong");
	a_fetch_eight: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(state_reg == ST_CHECK) |-> $past(wordIdx_reg) == W_LAST)
		else $error("decode started before eight words were read");
endmodule

// >>> tdd_pkg.sv
// Descriptor word indices, field positions and encodings for the descriptor engine
package tdd_pkg;
	localparam int DESC_WORDS  = 8;
	localparam int WORD_W      = 32;
	// Word indices inside one descriptor
	localparam logic [2:0] W_CTRL  = 3'h0;
	localparam logic [2:0] W_ROUTE = 3'h1;
	localparam logic [2:0] W_BUF   = 3'h2;
	localparam logic [2:0] W_STAT  = 3'h3;
	localparam logic [2:0] W_SLOT  = 3'h4;
	localparam logic [2:0] W_LAST  = 3'h7;
	// Word 0
	localparam int EP_LOW_BIT  = 31;
	localparam int MULT_HI     = 30;
	localparam int MULT_LO     = 29;
	localparam int MAXPKT_HI   = 28;
	localparam int MAXPKT_LO   = 18;
	localparam int TOTAL_HI    = 17;
	localparam int TOTAL_LO    = 3;
	localparam int VALID_BIT   = 0;
	// Word 1
	localparam int HUB_HI      = 31;
	localparam int HUB_LO      = 25;
	localparam int PORT_HI     = 24;
	localparam int PORT_LO     = 18;
	localparam int SPLIT_BIT   = 14;
	localparam int KIND_HI     = 13;
	localparam int KIND_LO     = 12;
	localparam int TOKEN_HI    = 11;
	localparam int TOKEN_LO    = 10;
	localparam int FADDR_HI    = 9;
	localparam int FADDR_LO    = 3;
	localparam int EP_UP_HI    = 2;
	localparam int EP_UP_LO    = 0;
	// Word 2
	localparam int RELOAD_HI   = 28;
	localparam int RELOAD_LO   = 25;
	localparam int BUF_HI      = 23;
	localparam int BUF_LO      = 8;
	localparam int FRAME_HI    = 7;
	localparam int FRAME_LO    = 3;
	// Word 3
	localparam int ACTIVE_BIT  = 31;
	localparam int HALT_BIT    = 30;
	localparam int TOGGLE_BIT  = 25;
	localparam int DONE_HI     = 14;
	// Word 4
	localparam int MASK_HI     = 7;
	// Encodings
	localparam logic [1:0] KIND_INTERRUPT = 2'h3;
	localparam logic [1:0] MULT_UNDEF     = 2'h0;
	localparam logic [1:0] MULT_SINGLE    = 2'h1;
	// Processor window base, internal address unit is 8 bytes
	localparam logic [17:0] CPU_MEM_BASE  = 18'h00400;
	localparam int          RAM_UNIT_LOG2 = 3;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FETCH = 3'b001,
		ST_CHECK = 3'b010,
		ST_ISSUE = 3'b011,
		ST_WAIT  = 3'b100,
		ST_WB3   = 3'b101,
		ST_WB0   = 3'b110
	} tdd_state_t;
endpackage

// >>> tdd_poll_check.sv
// Polling schedule check for periodic descriptors
`timescale 1ns/1ps
module tdd_poll_check
	import tdd_pkg::*;
(
	clk_sys,
	rst_b,
	isPeriodic,
	frameField,
	slotMask,
	frameLow,
	microframeIndex,
	due
);
	input  wire logic       clk_sys;
	input  wire logic       rst_b;
	input  wire logic       isPeriodic;
	input  wire logic [4:0] frameField;
	input  wire logic [7:0] slotMask;
	input  wire logic [4:0] frameLow;
	input  wire logic [2:0] microframeIndex;
	output logic            due;

	// Period in frames minus one, from the leading one of the frame field
	function automatic logic [4:0] periodMask(input logic [4:0] f);
		logic [4:0] m;
		m = 5'h00;
		if (f[4])
			m = 5'h1F;
		else if (f[3])
			m = 5'h0F;
		else if (f[2])
			m = 5'h07;
		else if (f[1])
			m = 5'h03;
		else if (f[0])
			m = 5'h01;
		return m;
	endfunction

	wire logic [4:0] pm       = periodMask(frameField);
	wire logic       phaseHit = (frameLow & pm) == (frameField & pm);
	wire logic       slotHit  = slotMask[microframeIndex];
	assign due = !isPeriodic || (phaseHit && slotHit);

	a_poll_slot_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(isPeriodic && due) |-> slotMask[microframeIndex])
		else $error("periodic descriptor due in an unselected microframe");
	a_poll_phase: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(isPeriodic && due && frameField[4]) |-> (frameLow == frameField))
		else $error("long period descriptor due in wrong frame");
endmodule

// >>> tdd_far_model.sv
// Far-side model: descriptor memory and packet transaction responder
`timescale 1ns/1ps
module tdd_far_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        memRdReq,
	input  wire logic        memWrEn,
	input  wire logic [7:0]  memAddr,
	input  wire logic [31:0] memWrData,
	output logic             memRdValid,
	output logic [31:0]      memRdData,
	input  wire logic        txnStart,
	input  wire logic [10:0] txnLen,
	output logic             txnDone,
	output logic [10:0]      txnBytes,
	output logic             txnFatal,
	output logic             txnToggleNext,
	input  wire logic        slowMode,
	input  wire logic        fatalMode
);
	logic [31:0] mem [0:255];
	logic [7:0]  rdAddr;
	logic [10:0] lenHold;
	int          rdCnt;
	int          txCnt;
	always @(posedge clk_sys or negedge rst_b)
		if (!rst_b)
		begin
			memRdValid <= 1'b0;
			memRdData <= 32'h0;
			txnDone <= 1'b0;
			txnBytes <= 11'h0;
			txnFatal <= 1'b0;
			txnToggleNext <= 1'b0;
			rdCnt <= 0;
			txCnt <= 0;
		end
		else
		begin
			memRdValid <= 1'b0;
			txnDone <= 1'b0;
			if (memWrEn)
				mem[memAddr] <= memWrData;
			// Released lines except txnToggleNext never repeat the last value
			memRdData <= ~memRdData;
			txnBytes <= ~txnBytes;
			txnFatal <= ~txnFatal;
			if (memRdReq)
			begin
				rdAddr <= memAddr;
				rdCnt <= slowMode ? 4 : 1;
			end
			else if (rdCnt > 1)
				rdCnt <= rdCnt - 1;
			else if (rdCnt == 1)
			begin
				rdCnt <= 0;
				memRdValid <= 1'b1;
				memRdData <= mem[rdAddr];
			end
			if (txnStart)
			begin
				lenHold <= txnLen;
				txCnt <= slowMode ? 6 : 1;
			end
			else if (txCnt > 1)
				txCnt <= txCnt - 1;
			else if (txCnt == 1)
			begin
				txCnt <= 0;
				txnDone <= 1'b1;
				txnBytes <= lenHold;
				txnFatal <= fatalMode;
				txnToggleNext <= 1'b1;
			end
		end
endmodule

// >>> testbench.sv
// Self-checking bench for the descriptor engine
`timescale 1ns/1ps
`define CHK(n, e, g) begin checksDone++; if ((e) !== (g)) begin mismatches++; \
	$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module testbench;
	import tdd_pkg::*;
	logic clk_sys = 0, rst_b = 0, sofTick = 0, scanEnable = 0, slow = 0, fatal = 0;
	logic [4:0] slot = 5'h0;
	logic [10:0] frameNumber = 11'h0;
	logic [2:0] mfIndex = 3'h0, rdNext = 3'h0;
	logic memRdReq, memWrEn, memRdValid, txnStart, txnToggle, txnSplit, txnDone;
	logic txnFatal, txnToggleNext, descBusy, descRetire, descFault;
	logic [7:0] memAddr;
	logic [31:0] memWrData, memRdData;
	logic [1:0] txnToken, txnKind;
	logic [6:0] txnFunctionAddr, txnHubAddr, txnHubPort;
	logic [3:0] txnEndpoint;
	logic [10:0] txnMaxBytes, txnLen, txnBytes;
	logic [15:0] txnBufAddr;
	int mismatches = 0, checksDone = 0, starts = 0, retires = 0, faults = 0;
	always #2.5 clk_sys = ~clk_sys;
	tdd_engine #(.SLOT_BITS(5)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .sofTick(sofTick),
		.scanEnable(scanEnable), .slotIndex(slot), .frameNumber(frameNumber),
		.microframeIndex(mfIndex), .memRdReq(memRdReq), .memWrEn(memWrEn), .memAddr(memAddr),
		.memWrData(memWrData), .memRdValid(memRdValid), .memRdData(memRdData),
		.txnStart(txnStart), .txnToken(txnToken), .txnKind(txnKind),
		.txnFunctionAddr(txnFunctionAddr), .txnEndpoint(txnEndpoint),
		.txnMaxBytes(txnMaxBytes), .txnLen(txnLen), .txnBufAddr(txnBufAddr),
		.txnToggle(txnToggle), .txnSplit(txnSplit), .txnHubAddr(txnHubAddr),
		.txnHubPort(txnHubPort), .txnDone(txnDone), .txnBytes(txnBytes),
		.txnFatal(txnFatal), .txnToggleNext(txnToggleNext), .descBusy(descBusy),
		.descRetire(descRetire), .descFault(descFault));
	tdd_far_model u_far (.clk_sys(clk_sys), .rst_b(rst_b), .memRdReq(memRdReq),
		.memWrEn(memWrEn), .memAddr(memAddr), .memWrData(memWrData),
		.memRdValid(memRdValid), .memRdData(memRdData), .txnStart(txnStart),
		.txnLen(txnLen), .txnDone(txnDone), .txnBytes(txnBytes), .txnFatal(txnFatal),
		.txnToggleNext(txnToggleNext), .slowMode(slow), .fatalMode(fatal));
	always @(posedge clk_sys)
	begin
		starts += txnStart;
		retires += descRetire;
		faults += descFault;
		if (memRdReq)
		begin
			`CHK("read order", {slot, rdNext}, memAddr)
			rdNext = rdNext + 3'h1;
		end
	end
	task automatic end_of_test;
		if (mismatches == 0 && checksDone > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Word 0: endpoint low bit, multiplier, max packet, total, valid
	function automatic logic [31:0] w0(logic e, logic [1:0] m, logic [10:0] p,
		logic [14:0] t, logic v);
		return {e, m, p, t, 2'b00, v};
	endfunction
	task automatic load(logic [31:0] a, b, c, d, e);
		u_far.mem[{slot, 3'h0}] = a;
		u_far.mem[{slot, 3'h1}] = b;
		u_far.mem[{slot, 3'h2}] = c;
		u_far.mem[{slot, 3'h3}] = d;
		u_far.mem[{slot, 3'h4}] = e;
		for (int i = 5; i < 8; i++)
			u_far.mem[{slot, i[2:0]}] = 32'h0;
	endtask
	task automatic run;
		int n;
		rdNext = 3'h0;
		@(posedge clk_sys) sofTick <= 1'b1;
		@(posedge clk_sys) sofTick <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		while (descBusy && n < 500);
		if (n >= 500)
		begin
			mismatches++;
			end_of_test();
		end
	endtask
	task automatic nextStart;
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		while (!txnStart && n < 300);
		if (n >= 300)
		begin
			mismatches++;
			end_of_test();
		end
	endtask
	task automatic bulkSingle;
		logic [31:0] a, b;
		a = w0(1'b1, MULT_SINGLE, 11'h040, 15'h0028, 1'b1);
		b = {7'h12, 7'h05, 3'b0, 1'b1, 2'h2, 2'h1, 7'h2A, 3'h5};
		slot = 5'h03;
		load(a, b, {3'h0, 4'h9, 1'b0, 16'h0123, 8'h00}, 32'h8000_0000, 32'h0);
		fork
			run();
			begin
				nextStart();
				`CHK("len", 11'h028, txnLen)
				`CHK("maxb", 11'h040, txnMaxBytes)
				`CHK("ep", 4'hB, txnEndpoint)
				`CHK("route", {7'h12, 7'h05, 2'h1, 2'h2, 7'h2A}, {txnHubAddr, txnHubPort,
					txnToken, txnKind, txnFunctionAddr})
				`CHK("split", 1'b1, txnSplit)
				`CHK("buf", 16'h0123, txnBufAddr)
			end
		join
		`CHK("retire", 1, retires)
		`CHK("w0 clr", a & ~32'h1, u_far.mem[{slot, 3'h0}])
		`CHK("w1 kept", b, u_far.mem[{slot, 3'h1}])
		`CHK("w3", 16'h0028, {u_far.mem[{slot, 3'h3}][31], u_far.mem[{slot, 3'h3}][14:0]})
	endtask
	task automatic bulkMult;
		logic [31:0] a;
		int s;
		s = starts;
		a = w0(1'b0, 2'h3, 11'h040, 15'h00C8, 1'b1);
		slow = 1'b1;
		slot = 5'h1F;
		load(a, 32'h0000_1000, {8'h0, 16'h0200, 8'h00}, 32'h8000_0000, 32'h0);
		fork
			run();
			for (int i = 0; i < 3; i++)
			begin
				nextStart();
				`CHK("mlen", 11'h040, txnLen)
				`CHK("mbuf", 16'h0200 + 16'(i * 8), txnBufAddr)
				`CHK("hs", 1'b0, txnSplit)
				`CHK("mtog", i != 0, txnToggle)
			end
		join
		`CHK("mcount", 3, starts - s)
		`CHK("w0 held", a, u_far.mem[{slot, 3'h0}])
		`CHK("mw3", 16'h80C0, {u_far.mem[{slot, 3'h3}][31], u_far.mem[{slot, 3'h3}][14:0]})
		slow = 1'b0;
	endtask
	task automatic faultAndSkip;
		logic [31:0] a;
		fatal = 1'b1;
		slot = 5'h05;
		a = w0(1'b0, 2'h1, 11'h010, 15'h0100, 1'b1);
		load(a, 32'h0000_1000, 32'h0, 32'h8000_0000, 32'h0);
		run();
		`CHK("fault", 1, faults)
		`CHK("fw0", a & ~32'h1, u_far.mem[{slot, 3'h0}])
		`CHK("halt", 2'b01, u_far.mem[{slot, 3'h3}][31:30])
		fatal = 1'b0;
		run();
		`CHK("skip", 5, starts)
		`CHK("skip w0", a & ~32'h1, u_far.mem[{slot, 3'h0}])
	endtask
	task automatic poll(logic [4:0] fr, logic [7:0] mask, logic [10:0] fn,
		logic [2:0] mf, int issue);
		int s;
		s = starts;
		slot = 5'h08;
		load(w0(1'b0, 2'h1, 11'h008, 15'h0008, 1'b1), {18'h0, KIND_INTERRUPT, 12'h0},
			{24'h0, fr, 3'h0}, 32'h8000_0000, {24'h0, mask});
		frameNumber <= fn;
		mfIndex <= mf;
		run();
		`CHK("poll", issue, starts - s)
	endtask
	initial
	begin
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		scanEnable <= 1'b1;
		bulkSingle();
		bulkMult();
		faultAndSkip();
		poll(5'h00, 8'hFF, 11'h000, 3'h5, 1);
		poll(5'h00, 8'h55, 11'h000, 3'h1, 0);
		poll(5'h00, 8'h55, 11'h000, 3'h2, 1);
		poll(5'h02, 8'h01, 11'h005, 3'h0, 0);
		poll(5'h02, 8'h01, 11'h006, 3'h0, 1);
		poll(5'h11, 8'h08, 11'h031, 3'h3, 1);
		poll(5'h11, 8'h08, 11'h031, 3'h2, 0);
		end_of_test();
	end
endmodule
